/* rtl/tstc_pkg.sv */
package tstc_pkg;

  // Register map
  localparam logic [7:0] ADDR_TIMING    = 8'h22;
  localparam logic [7:0] ADDR_HOLD_DET  = 8'h23;
  localparam logic [7:0] ADDR_AVG_SAMP  = 8'h24;
  localparam logic [7:0] RST_TIMING     = 8'hA4;
  localparam logic [7:0] RST_HOLD_DET   = 8'h07;
  localparam logic [7:0] RST_AVG_SAMP   = 8'h39;
  localparam logic [7:0] MASK_HOLD_DET  = 8'h0F;
  localparam logic [7:0] MASK_AVG_SAMP  = 8'h7F;

  // Field positions
  localparam int HOLD_LIMIT_LSB = 4;
  localparam int REPEAT_LSB     = 0;
  localparam int HOLD_DET_LSB   = 0;
  localparam int AVG_LSB        = 4;
  localparam int SAMP_LSB       = 2;
  localparam int CYCLE_LSB      = 0;

  // Time base
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_US       = 10;
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int STEP_MS       = 35;
  localparam int STEP_TICKS    = STEP_MS * 1000 / TICK_US;

  localparam int HOLD_LIMIT_MS [16] = '{560, 840, 1120, 1400, 1680, 2240, 2800, 3360,
                                        3920, 4480, 5600, 6720, 7840, 8906, 10080, 11200};
  localparam int SAMPLE_US [4] = '{320, 640, 1280, 2560};
  localparam int CYCLE_MS  [4] = '{35, 70, 105, 140};

  localparam int NCHAN  = 8;
  localparam int SDW    = 16;
  localparam int ACC_W  = 23;

  typedef logic [20:0] tstc_ticks_t;

  typedef enum logic [1:0] {
    TSTC_IDLE   = 2'b00,
    TSTC_SAMPLE = 2'b01,
    TSTC_LOWPWR = 2'b11
  } tstc_state_t;

endpackage : tstc_pkg

/* rtl/tstc_hold_timer.sv */
`timescale 1ns/10ps
module tstc_hold_timer (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // Time base, pad and enables
  input  wire logic                 tick_i,
  input  wire logic                 touch_i,
  input  wire logic                 rpt_en_i,
  input  wire logic                 recal_en_i,
  // Settings in ticks
  input  wire tstc_pkg::tstc_ticks_t hold_limit_i,
  input  wire tstc_pkg::tstc_ticks_t hold_det_i,
  input  wire tstc_pkg::tstc_ticks_t repeat_i,
  // Events
  output logic                      intr_o,
  output logic                      hold_evt_o,
  output logic                      touch_evt_o,
  output logic                      recal_o
);

  logic                  touched_q;
  logic                  holding_q;
  tstc_pkg::tstc_ticks_t dur_q;
  tstc_pkg::tstc_ticks_t dur_d;
  tstc_pkg::tstc_ticks_t rpt_q;
  tstc_pkg::tstc_ticks_t rpt_d;

  wire rise_w      = touch_i & ~touched_q;
  wire fall_w      = ~touch_i & touched_q;
  wire hold_hit_w  = tick_i & touch_i & rpt_en_i & ~holding_q & (dur_q == hold_det_i); // RQ3
  wire rpt_hit_w   = tick_i & touch_i & holding_q & (rpt_q == repeat_i - 21'd1);     // RQ15
  wire recal_hit_w = tick_i & touch_i & recal_en_i & (dur_q == hold_limit_i);        // RQ14

  // Duration restarts after a forced recalibration so a stuck pad retries periodically
  assign dur_d = (~touch_i | recal_hit_w) ? '0 :
                 (tick_i & (dur_q != '1)) ? dur_q + 21'd1 : dur_q; // RQ17
  assign rpt_d = (~holding_q | rpt_hit_w) ? '0 : tick_i ? rpt_q + 21'd1 : rpt_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      touched_q   <= 1'b0;
      holding_q   <= 1'b0;
      dur_q       <= '0;
      rpt_q       <= '0;
      intr_o      <= 1'b0;
      hold_evt_o  <= 1'b0;
      touch_evt_o <= 1'b0;
      recal_o     <= 1'b0;
    end else begin
      touched_q   <= touch_i;
      holding_q   <= touch_i & (holding_q | hold_hit_w);
      dur_q       <= dur_d;
      rpt_q       <= rpt_d;
      intr_o      <= rise_w | hold_hit_w | rpt_hit_w; // RQ15
      hold_evt_o  <= hold_hit_w;
      touch_evt_o <= fall_w & rpt_en_i & ~holding_q; // RQ4
      recal_o     <= recal_hit_w; // RQ1
    end
  end

  property p_recal_gated;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    recal_o |-> $past(recal_en_i) && $past(dur_q) == $past(hold_limit_i);
  endproperty
  a_recal_gated: assert property (p_recal_gated) // RQ14
    else $error("recal without enable or time");

  property p_hold_at_time;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    hold_evt_o |-> $past(rpt_en_i) && $past(dur_q) == $past(hold_det_i) && intr_o;
  endproperty
  a_hold_at_time: assert property (p_hold_at_time) else $error("hold event at wrong time"); // RQ3

  property p_short_touch;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    touch_evt_o |-> $past(dur_q) <= $past(hold_det_i) && !$past(touch_i);
  endproperty
  a_short_touch: assert property (p_short_touch) else $error("touch event after hold time"); // RQ4

  property p_no_hold_without_rpt;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !rpt_en_i ##1 !rpt_en_i |-> !hold_evt_o;
  endproperty
  a_no_hold_without_rpt: assert property (p_no_hold_without_rpt) // RQ3
    else $error("hold without repeat");

  c_hold_repeat: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    hold_evt_o ##[1:1000] (intr_o & holding_q));

endmodule : tstc_hold_timer

/* rtl/tstc_timing_core.sv */
`timescale 1ns/10ps
// How it works
// RQ1: Long touch recalibrates after decoded hold limit
// RQ2: Repeat interval is code plus one times 35ms
// RQ3: Auto-repeat touch past hold time means press-and-hold
// RQ4: Shorter auto-repeat touch is an ordinary touch
// RQ5: Hold detect is code plus one times 35ms
// RQ6: Averaging takes two to the code samples
// RQ7: Channel samples back to back, result is average
// RQ8: Sample duration 320us, 640us, 1.28ms or 2.56ms
// RQ9: Cycle period 35, 70, 105 or 140ms
// RQ10: Sample first, then low power for remainder
// RQ11: Long sampling stretches the cycle, samples win
// RQ12: Sensing runs only in Active state
// RQ13: Hold limit and repeat shared by all inputs
// RQ14: Recalibration only while global enable set
// RQ15: Interrupt at hold detection and each repeat
// RQ16: Cycle length independent of enabled input count
// RQ17: All durations counted in time-base ticks
module tstc_timing_core (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Global and per-input controls
  input  wire logic        active_i,
  input  wire logic        hold_limit_recal_en_i,
  input  wire logic [7:0]  chan_en_i,
  input  wire logic [7:0]  rpt_en_i,
  // Analog front end
  input  wire logic [7:0]  touch_inputs_i,
  input  wire logic [15:0] sample_data_i,
  output logic             sample_active_o,
  output logic      [2:0]  sample_chan_o,
  output logic             sample_end_o,
  output logic             low_power_o,
  // Measurement results
  output logic             result_valid_o,
  output logic      [2:0]  result_chan_o,
  output logic      [15:0] result_o,
  // Per-input events
  output logic      [7:0]  intr_o,
  output logic      [7:0]  hold_evt_o,
  output logic      [7:0]  touch_evt_o,
  output logic      [7:0]  recal_o
);

  logic [7:0]                 timing_q;
  logic [7:0]                 hold_det_q;
  logic [7:0]                 avg_samp_q;
  logic [7:0]                 rdata_d;
  logic [7:0]                 tick_cnt_q;
  tstc_pkg::tstc_state_t      state_q;
  tstc_pkg::tstc_state_t      state_d;
  logic [2:0]                 chan_q;
  logic [8:0]                 samp_cnt_q;
  logic [6:0]                 nsamp_q;
  logic [tstc_pkg::ACC_W-1:0] acc_q;
  tstc_pkg::tstc_ticks_t      cyc_q;

  // Register decode
  wire wr_timing_w   = reg_wr_i & (reg_addr_i == tstc_pkg::ADDR_TIMING);
  wire wr_hold_det_w = reg_wr_i & (reg_addr_i == tstc_pkg::ADDR_HOLD_DET);
  wire wr_avg_samp_w = reg_wr_i & (reg_addr_i == tstc_pkg::ADDR_AVG_SAMP);

  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr_i)
      tstc_pkg::ADDR_TIMING:   rdata_d = timing_q;
      tstc_pkg::ADDR_HOLD_DET: rdata_d = hold_det_q;
      tstc_pkg::ADDR_AVG_SAMP: rdata_d = avg_samp_q;
      default:                 rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timing_q    <= tstc_pkg::RST_TIMING;
      hold_det_q  <= tstc_pkg::RST_HOLD_DET;
      avg_samp_q  <= tstc_pkg::RST_AVG_SAMP;
      reg_rdata_o <= 8'h00;
    end else begin
      if (wr_timing_w) timing_q <= reg_wdata_i;
      if (wr_hold_det_w) hold_det_q <= reg_wdata_i & tstc_pkg::MASK_HOLD_DET;
      if (wr_avg_samp_w) avg_samp_q <= reg_wdata_i & tstc_pkg::MASK_AVG_SAMP;
      if (reg_rd_i) reg_rdata_o <= rdata_d;
    end
  end

  // Field decode into tick counts and the last sample index
  wire [3:0] hold_limit_sel_w      = timing_q[tstc_pkg::HOLD_LIMIT_LSB +: 4];
  wire [3:0] repeat_interval_sel_w = timing_q[tstc_pkg::REPEAT_LSB +: 4];
  wire [3:0] hold_det_sel_w        = hold_det_q[tstc_pkg::HOLD_DET_LSB +: 4];
  wire [2:0] samples_per_measure_sel_w = avg_samp_q[tstc_pkg::AVG_LSB +: 3];
  wire [1:0] sample_duration_sel_w = avg_samp_q[tstc_pkg::SAMP_LSB +: 2];
  wire [1:0] cycle_sel_w           = avg_samp_q[tstc_pkg::CYCLE_LSB +: 2];

  wire tstc_pkg::tstc_ticks_t hold_limit_w = tstc_pkg::tstc_ticks_t'(
    tstc_pkg::HOLD_LIMIT_MS[hold_limit_sel_w] * 1000 / tstc_pkg::TICK_US); // RQ1
  wire tstc_pkg::tstc_ticks_t repeat_w = tstc_pkg::tstc_ticks_t'(
    (int'(repeat_interval_sel_w) + 1) * tstc_pkg::STEP_TICKS); // RQ2
  wire tstc_pkg::tstc_ticks_t hold_det_w = tstc_pkg::tstc_ticks_t'(
    (int'(hold_det_sel_w) + 1) * tstc_pkg::STEP_TICKS); // RQ5
  wire [8:0] samp_len_w = 9'(
    tstc_pkg::SAMPLE_US[sample_duration_sel_w] / tstc_pkg::TICK_US); // RQ8
  wire tstc_pkg::tstc_ticks_t cyc_len_w = tstc_pkg::tstc_ticks_t'(
    tstc_pkg::CYCLE_MS[cycle_sel_w] * 1000 / tstc_pkg::TICK_US); // RQ9
  wire [6:0] n_last_w = 7'((8'd1 << samples_per_measure_sel_w) - 8'd1); // RQ6

  // Time base
  wire tick_w = (tick_cnt_q == 8'(tstc_pkg::TICK_CYCLES - 1)); // RQ17

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) tick_cnt_q <= 8'h00;
    else tick_cnt_q <= tick_w ? 8'h00 : tick_cnt_q + 8'h01;
  end

  // Sampling sequence
  wire in_sample_w   = (state_q == tstc_pkg::TSTC_SAMPLE);
  wire chan_on_w     = chan_en_i[chan_q];
  wire skip_w        = in_sample_w & ~chan_on_w; // RQ16
  wire samp_last_w   = tick_w & (samp_cnt_q == samp_len_w - 9'd1);
  wire done_sample_w = in_sample_w & chan_on_w & samp_last_w;
  wire meas_done_w   = done_sample_w & (nsamp_q == n_last_w); // RQ7
  wire advance_w     = skip_w | meas_done_w;
  wire last_chan_w   = (chan_q == 3'(tstc_pkg::NCHAN - 1));
  wire scan_end_w    = advance_w & last_chan_w;
  // Sampling may overrun the period; the wait then ends at the next tick
  wire cyc_end_w     = tick_w & (cyc_q >= cyc_len_w - 21'd1); // RQ11
  wire restart_w     = (state_q == tstc_pkg::TSTC_LOWPWR) & cyc_end_w;

  wire [tstc_pkg::ACC_W-1:0] acc_sum_w = acc_q +
    {{(tstc_pkg::ACC_W - tstc_pkg::SDW){1'b0}}, sample_data_i};
  wire [tstc_pkg::ACC_W-1:0] avg_w     = acc_sum_w >> samples_per_measure_sel_w;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tstc_pkg::TSTC_IDLE:   if (active_i) state_d = tstc_pkg::TSTC_SAMPLE;
      tstc_pkg::TSTC_SAMPLE: if (scan_end_w) state_d = tstc_pkg::TSTC_LOWPWR; // RQ10
      tstc_pkg::TSTC_LOWPWR: if (restart_w) state_d = tstc_pkg::TSTC_SAMPLE;
      default:               state_d = tstc_pkg::TSTC_IDLE;
    endcase
    if (!active_i) state_d = tstc_pkg::TSTC_IDLE; // RQ12
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) state_q <= tstc_pkg::TSTC_IDLE;
    else state_q <= state_d;
  end

  // Cycle timer runs from the start of sampling, so the scan time counts toward the period
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) cyc_q <= '0;
    else if (state_q == tstc_pkg::TSTC_IDLE || restart_w) cyc_q <= '0;
    else if (tick_w && cyc_q != '1) cyc_q <= cyc_q + 21'd1;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_q     <= 3'd0;
      samp_cnt_q <= 9'd0;
      nsamp_q    <= 7'd0;
      acc_q      <= '0;
    end else if (!in_sample_w) begin
      chan_q     <= 3'd0;
      samp_cnt_q <= 9'd0;
      nsamp_q    <= 7'd0;
      acc_q      <= '0;
    end else begin
      if (advance_w) chan_q <= chan_q + 3'd1;
      if (!chan_on_w || samp_last_w) samp_cnt_q <= 9'd0;
      else if (tick_w) samp_cnt_q <= samp_cnt_q + 9'd1;
      if (advance_w) begin
        nsamp_q <= 7'd0;
        acc_q   <= '0;
      end else if (done_sample_w) begin
        nsamp_q <= nsamp_q + 7'd1;
        acc_q   <= acc_sum_w;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_valid_o <= 1'b0;
      result_chan_o  <= 3'd0;
      result_o       <= 16'h0000;
    end else begin
      result_valid_o <= meas_done_w;
      if (meas_done_w) begin
        result_chan_o <= chan_q;
        result_o      <= avg_w[tstc_pkg::SDW-1:0]; // RQ7
      end
    end
  end

  assign sample_active_o = in_sample_w & chan_on_w;
  assign sample_chan_o   = chan_q;
  assign sample_end_o    = done_sample_w;
  assign low_power_o     = (state_q == tstc_pkg::TSTC_LOWPWR); // RQ10

  // Shared settings feed every input alike
  for (genvar i = 0; i < tstc_pkg::NCHAN; i++) begin : g_input
    tstc_hold_timer u_hold (
      .clk_sys_i    (clk_sys_i),
      .nrst_i       (nrst_i),
      .tick_i       (tick_w),
      .touch_i      (touch_inputs_i[i]),
      .rpt_en_i     (rpt_en_i[i]),
      .recal_en_i   (hold_limit_recal_en_i),
      .hold_limit_i (hold_limit_w), // RQ13
      .hold_det_i   (hold_det_w),
      .repeat_i     (repeat_w),
      .intr_o       (intr_o[i]),
      .hold_evt_o   (hold_evt_o[i]),
      .touch_evt_o  (touch_evt_o[i]),
      .recal_o      (recal_o[i])
    );
  end

  property p_inactive_idle;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    !active_i |=> !sample_active_o && !low_power_o;
  endproperty
  a_inactive_idle: assert property (p_inactive_idle) else $error("sensing while inactive"); // RQ12

  property p_lowpwr_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    low_power_o |-> !sample_active_o && !sample_end_o;
  endproperty
  a_lowpwr_quiet: assert property (p_lowpwr_quiet) else $error("sampling in low power"); // RQ10

  property p_result_count;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    result_valid_o |-> $past(nsamp_q) == $past(n_last_w) && $past(sample_end_o);
  endproperty
  a_result_count: assert property (p_result_count) else $error("result before all samples"); // RQ6

  property p_result_chan;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    result_valid_o |-> result_chan_o == $past(chan_q);
  endproperty
  a_result_chan: assert property (p_result_chan) else $error("result for wrong channel"); // RQ7

  property p_cycle_length;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    $past(low_power_o) && !low_power_o && active_i |-> $past(cyc_q) >= $past(cyc_len_w) - 21'd1;
  endproperty
  a_cycle_length: assert property (p_cycle_length) else $error("cycle shorter than period"); // RQ9

  property p_sample_length;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    sample_end_o |-> samp_cnt_q == samp_len_w - 9'd1 && tick_w;
  endproperty
  a_sample_length: assert property (p_sample_length) else $error("sample length wrong"); // RQ8

  property p_scan_then_wait;
    @(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(low_power_o) |-> $past(in_sample_w) && $past(chan_q) == 3'd7;
  endproperty
  a_scan_then_wait: assert property (p_scan_then_wait) // RQ11
    else $error("idle before scan done");

  c_full_cycle: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $rose(low_power_o) ##[1:1000] $fell(low_power_o));
  c_result: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) result_valid_o);
  c_recal: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) |recal_o);

endmodule : tstc_timing_core

/* sim/tstc_afe_model.sv */
`timescale 1ns/10ps
module tstc_afe_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Scan status from the core
  input  wire logic        sample_active_i,
  input  wire logic [2:0]  sample_chan_i,
  input  wire logic        sample_end_i,
  // Raw sample
  output logic      [15:0] sample_data_o
);
  logic        phase_q;
  logic [15:0] level_w;

  // Alternating low bits make an average differ from any single sample
  assign level_w = {1'b0, sample_chan_i, 12'h000} | (phase_q ? 16'h0020 : 16'h0000);
  // The converter does not hold its output between samples, so show the inverse
  assign sample_data_o = sample_active_i ? level_w : ~level_w;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= 1'b0;
    end else if (sample_end_i) begin
      phase_q <= ~phase_q;
    end
  end
endmodule : tstc_afe_model

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
  logic        clk_sys_i;
  logic        nrst_i;
  logic [7:0]  reg_addr_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic        active_i;
  logic        hold_limit_recal_en_i;
  logic [7:0]  chan_en_i;
  logic [7:0]  rpt_en_i;
  logic [7:0]  touch_inputs_i;
  logic [15:0] sample_data_i;
  logic        sample_active_o;
  logic [2:0]  sample_chan_o;
  logic        sample_end_o;
  logic        low_power_o;
  logic        result_valid_o;
  logic [2:0]  result_chan_o;
  logic [15:0] result_o;
  logic [7:0]  intr_o;
  logic [7:0]  hold_evt_o;
  logic [7:0]  touch_evt_o;
  logic [7:0]  recal_o;
  int          fails;
  int          checks;
  int          cyc;
  int          end_cyc[$];
  logic [2:0]  end_chan[$];
  logic [15:0] res_val[$];
  logic [2:0]  res_chan[$];
  logic        odd_evt;
  logic [7:0]  d;
  logic [7:0]  ra[3] = '{tstc_pkg::ADDR_TIMING, tstc_pkg::ADDR_HOLD_DET, tstc_pkg::ADDR_AVG_SAMP};
  logic [7:0]  rv[3] = '{tstc_pkg::RST_TIMING, tstc_pkg::RST_HOLD_DET, tstc_pkg::RST_AVG_SAMP};

  tstc_timing_core tstc_timing_core_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .active_i(active_i), .hold_limit_recal_en_i(hold_limit_recal_en_i),
    .chan_en_i(chan_en_i), .rpt_en_i(rpt_en_i), .touch_inputs_i(touch_inputs_i),
    .sample_data_i(sample_data_i), .sample_active_o(sample_active_o),
    .sample_chan_o(sample_chan_o), .sample_end_o(sample_end_o), .low_power_o(low_power_o),
    .result_valid_o(result_valid_o), .result_chan_o(result_chan_o), .result_o(result_o),
    .intr_o(intr_o), .hold_evt_o(hold_evt_o), .touch_evt_o(touch_evt_o), .recal_o(recal_o)
  );

  tstc_afe_model tstc_afe_model_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sample_active_i(sample_active_o),
    .sample_chan_i(sample_chan_o), .sample_end_i(sample_end_o), .sample_data_o(sample_data_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Record scan events with their cycle number for later timing checks
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (sample_end_o === 1'b1) begin
      end_cyc.push_back(cyc);
      end_chan.push_back(sample_chan_o);
    end
    if (result_valid_o === 1'b1) begin
      res_val.push_back(result_o);
      res_chan.push_back(result_chan_o);
    end
    if ((|hold_evt_o === 1'b1) || (|recal_o === 1'b1)) odd_evt = 1'b1;
    // Input 4 has no auto repeat, so it must never report a short touch
    if (touch_evt_o[4] === 1'b1) odd_evt = 1'b1;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i); #1;
    reg_addr_i = a; reg_wdata_i = v; reg_wr_i = 1'b1;
    @(posedge clk_sys_i); #1;
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i); #1;
    reg_addr_i = a; reg_rd_i = 1'b1;
    @(posedge clk_sys_i); #1;
    reg_rd_i = 1'b0; v = reg_rdata_o;
  endtask : rd

  task automatic wait_results(input int n);
    int i;
    for (i = 0; i < 40000 && res_val.size() < n; i++) @(posedge clk_sys_i);
    chk("results arrived", 16'(res_val.size() >= n), 16'h0001);
  endtask : wait_results

  // k-th measured channel: two back-to-back samples, then their average
  task automatic check_chan(input int k, input logic [2:0] ch, input int gap);
    chk("sample chan a", 16'(end_chan[2*k]), 16'(ch));
    chk("sample chan b", 16'(end_chan[2*k+1]), 16'(ch));
    chk("sample length", 16'(end_cyc[2*k+1] - end_cyc[2*k]), 16'(gap));
    chk("result chan", 16'(res_chan[k]), 16'(ch));
    chk("result avg", res_val[k], {1'b0, ch, 12'h010});
  endtask : check_chan

  task automatic seek(input string nm, input bit evt, input int idx, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk_sys_i); #1;
      if ((evt ? touch_evt_o[idx] : intr_o[idx]) === 1'b1) seen = 1'b1;
    end
    chk(nm, 16'(seen), 16'(exp));
  endtask : seek

  task report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Two scans of about 32000 cycles each plus register traffic
  initial begin
    #(90000 * 40);
    fails++;
    report_and_stop;
  end

  initial begin
    nrst_i = 1'b0; active_i = 1'b0; hold_limit_recal_en_i = 1'b1;
    chan_en_i = 8'h05; rpt_en_i = 8'hef; touch_inputs_i = 8'h00;
    reg_addr_i = 8'h00; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_wdata_i = 8'h00;
    fails = 0; checks = 0; cyc = 0; odd_evt = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(ra[i], d);
      chk("reset value", 16'(d), 16'(rv[i]));
    end
    wr(tstc_pkg::ADDR_HOLD_DET, 8'hff);
    wr(tstc_pkg::ADDR_AVG_SAMP, 8'hff);
    wr(tstc_pkg::ADDR_TIMING, 8'h5a);
    wr(8'h25, 8'hff);
    rd(tstc_pkg::ADDR_HOLD_DET, d);
    chk("hold detect rw", 16'(d), 16'h000f);
    rd(tstc_pkg::ADDR_AVG_SAMP, d);
    chk("avg samp rw", 16'(d), 16'h007f);
    rd(tstc_pkg::ADDR_TIMING, d);
    chk("timing rw", 16'(d), 16'h005a);
    rd(8'h25, d);
    chk("unmapped", 16'(d), 16'h0000);
    chk("idle when inactive", 16'(sample_active_o), 16'h0000);
    // Two 320us samples per channel, channel 1 skipped
    wr(tstc_pkg::ADDR_AVG_SAMP, 8'h10);
    wr(tstc_pkg::ADDR_HOLD_DET, 8'h07);
    end_cyc.delete(); end_chan.delete(); res_val.delete(); res_chan.delete();
    active_i = 1'b1;
    wait_results(2);
    check_chan(0, 3'd0, 8000);
    check_chan(1, 3'd2, 8000);
    repeat (4) @(posedge clk_sys_i);
    #1 chk("low power after scan", 16'(low_power_o), 16'h0001);
    chk("no sampling in wait", 16'(sample_active_o), 16'h0000);
    // Short touches: one with auto repeat, one without
    touch_inputs_i = 8'h18;
    seek("touch onset intr", 1'b0, 3, 1'b1);
    repeat (100) @(posedge clk_sys_i);
    #1 touch_inputs_i = 8'h00;
    seek("short touch event", 1'b1, 3, 1'b1);
    chk("no event without repeat", 16'(odd_evt), 16'h0000);
    // Second reset in mid-run, then 640us samples on the last input only
    nrst_i = 1'b0;
    active_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    rd(tstc_pkg::ADDR_AVG_SAMP, d);
    chk("reset again", 16'(d), 16'(tstc_pkg::RST_AVG_SAMP));
    wr(tstc_pkg::ADDR_AVG_SAMP, 8'h14);
    chan_en_i = 8'h80;
    end_cyc.delete(); end_chan.delete(); res_val.delete(); res_chan.delete();
    active_i = 1'b1;
    wait_results(1);
    check_chan(0, 3'd7, 16000);
    chk("no hold or recal", 16'(odd_evt), 16'h0000);
    report_and_stop;
  end
endmodule : tb
